// ### cso_pkg.sv
// Package with the register map and frame constants of the checksum control
`default_nettype none

package cso_pkg;

    // APB map: a single 32-bit control word
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CTRL_OFFSET = 12'h130;

    // Field positions inside the control word
    localparam int unsigned TX_ENABLE_BIT = 16;
    localparam int unsigned RX_START_SELECT_BIT = 1;
    localparam int unsigned RX_ENABLE_BIT = 0;

    // Writable bits; everything else is reserved and reads zero
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h0001_0003;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Frame layout used to locate the start of the layer-3 packet
    localparam logic [7:0] FIXED_START = 8'h0e;
    localparam logic [7:0] FIRST_TYPE_POS = 8'h0c;
    localparam logic [7:0] VLAN_TAG_LEN = 8'h04;
    localparam logic [7:0] SNAP_HDR_LEN = 8'h0a;
    localparam logic [7:0] TYPE_FIELD_LEN = 8'h02;
    localparam logic [15:0] VLAN_TPID = 16'h8100;
    localparam logic [15:0] MAX_LENGTH_FIELD = 16'h05dc;
    localparam logic [7:0] LLC_SNAP_SAP = 8'haa;
    localparam logic [7:0] LLC_UI_CTRL = 8'h03;
    localparam int unsigned MAX_VLAN_TAGS = 2;

    // Control fields as seen by the checksum engines
    typedef struct packed {
        logic tx_checksum_engine_enable;
        logic rx_checksum_start_select;
        logic rx_checksum_engine_enable;
    } cso_ctrl_t;

    // Receive header walker states
    typedef enum logic [1:0] {
        WALK_IDLE,
        WALK_TYPE,
        WALK_SNAP,
        WALK_DONE
    } cso_walk_t;

endpackage : cso_pkg

`default_nettype wire

// ### cso_control.sv
// Checksum offload control register with receive start-offset finder
//
// Overview of operation
// - Transmit engine bypassed when its enable is 0, applied at 1; resets 0.
// - Receive start select chooses fixed start or VLAN/SNAP aware start.
// - Start select 0: receive checksum starts after the first 14 bytes.
// - Start select 1: start at layer-3 packet, skipping up to MAX_TAGS VLAN tags and SNAP.
// - Receive engine bypassed when its enable is 0, applied at 1; resets 0.
//
// Our own choice: the APB slave port.
`default_nettype none

module cso_control #(
    parameter int unsigned MAX_TAGS = cso_pkg::MAX_VLAN_TAGS
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RX_FRAME_START,
    input wire logic RX_BYTE_VALID,
    input wire logic [7:0] RX_BYTE,
    output logic TX_CHECKSUM_ENGINE_ENABLE,
    output logic RX_CHECKSUM_ENGINE_ENABLE,
    output logic RX_CHECKSUM_START_SELECT,
    output logic [7:0] RX_L3_OFFSET,
    output logic RX_OFFSET_VALID
);

    // Byte-position arithmetic, kept 8 bits wide on purpose
    function automatic logic [7:0] pos_add(
        input logic [7:0] a,
        input logic [7:0] b
    );
        pos_add = 8'(a + b);
    endfunction : pos_add

    cso_pkg::cso_ctrl_t ctrl;
    cso_pkg::cso_ctrl_t next_ctrl;
    logic [31:0] next_prdata;
    logic ctrl_hit;
    logic ctrl_write;
    logic [31:0] ctrl_word;

    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign ctrl_hit = (PADDR == cso_pkg::CTRL_OFFSET);
    assign ctrl_write = PSEL & PENABLE & PWRITE & ctrl_hit;
    assign PSLVERR = PSEL & PENABLE & ~ctrl_hit;

    // Control word as read back; reserved positions stay zero
    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[cso_pkg::TX_ENABLE_BIT] = ctrl.tx_checksum_engine_enable;
        ctrl_word[cso_pkg::RX_START_SELECT_BIT] =
            ctrl.rx_checksum_start_select;
        ctrl_word[cso_pkg::RX_ENABLE_BIT] = ctrl.rx_checksum_engine_enable;
    end

    // Register update; only the three defined bits are stored
    always_comb
    begin
        next_ctrl = ctrl;
        next_prdata = PRDATA;
        if (ctrl_write)
        begin
            next_ctrl.tx_checksum_engine_enable =
                PWDATA[cso_pkg::TX_ENABLE_BIT];
            next_ctrl.rx_checksum_start_select =
                PWDATA[cso_pkg::RX_START_SELECT_BIT];
            next_ctrl.rx_checksum_engine_enable =
                PWDATA[cso_pkg::RX_ENABLE_BIT];
        end
        // Read data is captured in the setup cycle so it comes from a flop
        if (PSEL & ~PENABLE & ~PWRITE)
        begin
            next_prdata = ctrl_hit ? ctrl_word : 32'h0000_0000;
        end
    end

    // Both enables come up cleared, so the engines start bypassed
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            ctrl <= cso_pkg::cso_ctrl_t'(3'b000);
            PRDATA <= cso_pkg::CTRL_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
            PRDATA <= next_prdata;
        end
    end

    // Software is trusted to change fields only with the path idle, so no
    // shadow copy is held per frame
    assign TX_CHECKSUM_ENGINE_ENABLE = ctrl.tx_checksum_engine_enable;
    assign RX_CHECKSUM_ENGINE_ENABLE = ctrl.rx_checksum_engine_enable;
    assign RX_CHECKSUM_START_SELECT = ctrl.rx_checksum_start_select;

    cso_pkg::cso_walk_t walk;
    cso_pkg::cso_walk_t next_walk;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] type_pos;
    logic [7:0] next_type_pos;
    logic [7:0] type_hi;
    logic [7:0] next_type_hi;
    logic [1:0] tags;
    logic [1:0] next_tags;
    logic snap_ok;
    logic next_snap_ok;
    logic [7:0] next_l3_offset;
    logic next_offset_valid;
    logic [15:0] type_val;

    assign type_val = {type_hi, RX_BYTE};

    // Header walker: follows the type field through tags and SNAP
    always_comb
    begin
        next_walk = walk;
        next_cnt = cnt;
        next_type_pos = type_pos;
        next_type_hi = type_hi;
        next_tags = tags;
        next_snap_ok = snap_ok;
        next_l3_offset = RX_L3_OFFSET;
        next_offset_valid = 1'b0;
        if (RX_BYTE_VALID & RX_FRAME_START)
        begin
            // Byte 0 of a new frame; type field never sits this early
            next_walk = cso_pkg::WALK_TYPE;
            next_cnt = 8'h01;
            next_type_pos = cso_pkg::FIRST_TYPE_POS;
            next_tags = 2'b00;
            next_snap_ok = 1'b0;
        end
        else if (RX_BYTE_VALID)
        begin
            // Saturate so giant frames do not wrap into the header window
            next_cnt = (cnt == 8'hff) ? cnt : pos_add(cnt, 8'h01);
            case (walk)
                cso_pkg::WALK_TYPE:
                begin
                    if (cnt == type_pos)
                    begin
                        next_type_hi = RX_BYTE;
                    end
                    else if (cnt == pos_add(type_pos, 8'h01))
                    begin
                        if (!ctrl.rx_checksum_start_select)
                        begin
                            next_l3_offset = cso_pkg::FIXED_START;
                            next_offset_valid = 1'b1;
                            next_walk = cso_pkg::WALK_DONE;
                        end
                        else if (type_val == cso_pkg::VLAN_TPID &&
                                 32'(tags) < MAX_TAGS)
                        begin
                            next_type_pos =
                                pos_add(type_pos, cso_pkg::VLAN_TAG_LEN);
                            next_tags = 2'(tags + 2'b01);
                        end
                        else if (type_val <= cso_pkg::MAX_LENGTH_FIELD)
                        begin
                            next_walk = cso_pkg::WALK_SNAP;
                        end
                        else
                        begin
                            next_l3_offset =
                                pos_add(type_pos, cso_pkg::TYPE_FIELD_LEN);
                            next_offset_valid = 1'b1;
                            next_walk = cso_pkg::WALK_DONE;
                        end
                    end
                end
                cso_pkg::WALK_SNAP:
                begin
                    // LLC header must be AA AA 03 to carry a SNAP header
                    if (cnt == pos_add(type_pos, 8'h02))
                    begin
                        next_snap_ok = (RX_BYTE == cso_pkg::LLC_SNAP_SAP);
                    end
                    else if (cnt == pos_add(type_pos, 8'h03))
                    begin
                        next_snap_ok =
                            snap_ok & (RX_BYTE == cso_pkg::LLC_SNAP_SAP);
                    end
                    else if (cnt == pos_add(type_pos, 8'h04))
                    begin
                        if (snap_ok && RX_BYTE == cso_pkg::LLC_UI_CTRL)
                        begin
                            next_l3_offset =
                                pos_add(type_pos, cso_pkg::SNAP_HDR_LEN);
                        end
                        else
                        begin
                            next_l3_offset =
                                pos_add(type_pos, cso_pkg::TYPE_FIELD_LEN);
                        end
                        next_offset_valid = 1'b1;
                        next_walk = cso_pkg::WALK_DONE;
                    end
                end
                cso_pkg::WALK_IDLE,
                cso_pkg::WALK_DONE:
                begin
                    next_walk = walk;
                end
                default:
                begin
                    next_walk = cso_pkg::WALK_IDLE;
                end
            endcase
        end
    end

    // Walker registers
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            walk <= cso_pkg::WALK_IDLE;
            cnt <= 8'h00;
            type_pos <= cso_pkg::FIRST_TYPE_POS;
            type_hi <= 8'h00;
            tags <= 2'b00;
            snap_ok <= 1'b0;
            RX_L3_OFFSET <= cso_pkg::FIXED_START;
            RX_OFFSET_VALID <= 1'b0;
        end
        else
        begin
            walk <= next_walk;
            cnt <= next_cnt;
            type_pos <= next_type_pos;
            type_hi <= next_type_hi;
            tags <= next_tags;
            snap_ok <= next_snap_ok;
            RX_L3_OFFSET <= next_l3_offset;
            RX_OFFSET_VALID <= next_offset_valid;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);
    chk_tx_enable_write: assert property (
        ctrl_write |=> TX_CHECKSUM_ENGINE_ENABLE ==
            $past(PWDATA[cso_pkg::TX_ENABLE_BIT]))
        else $error("transmit enable did not follow write");
    chk_rx_enable_write: assert property (
        ctrl_write |=> RX_CHECKSUM_ENGINE_ENABLE ==
            $past(PWDATA[cso_pkg::RX_ENABLE_BIT]))
        else $error("receive enable did not follow write");
    chk_enable_hold: assert property (
        !ctrl_write |=> $stable(RX_CHECKSUM_ENGINE_ENABLE) &&
            $stable(TX_CHECKSUM_ENGINE_ENABLE))
        else $error("enable changed without a write");
    chk_reserved_zero: assert property (
        PSEL && PENABLE && !PWRITE |->
            (PRDATA & ~cso_pkg::CTRL_WRITE_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    chk_fixed_offset: assert property (
        RX_OFFSET_VALID && !RX_CHECKSUM_START_SELECT |->
            RX_L3_OFFSET == 8'h0e)
        else $error("fixed start offset is not 14");
    chk_fixed_timing: assert property (
        !RX_CHECKSUM_START_SELECT && RX_BYTE_VALID && cnt == 8'h0d &&
            walk == cso_pkg::WALK_TYPE && !RX_FRAME_START
            |=> RX_OFFSET_VALID)
        else $error("fixed start not reported after byte 13");
    chk_select_path: assert property (
        RX_OFFSET_VALID && RX_L3_OFFSET != 8'h0e |->
            RX_CHECKSUM_START_SELECT)
        else $error("adjusted start without start select");
    chk_l3_plain_type: assert property (
        ctrl.rx_checksum_start_select && RX_BYTE_VALID && !RX_FRAME_START &&
            walk == cso_pkg::WALK_TYPE && cnt == 8'h0d &&
            type_val > 16'h05dc && type_val != 16'h8100
            |=> RX_OFFSET_VALID && RX_L3_OFFSET == 8'h0e)
        else $error("untagged frame start is not 14");
    chk_l3_min: assert property (
        RX_OFFSET_VALID |-> RX_L3_OFFSET >= 8'h0e)
        else $error("start offset inside the MAC header");
endmodule : cso_control

`default_nettype wire

// ### cso_control_tb.sv
// Self-checking bench for the checksum offload control register
`default_nettype none

module cso_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic CLK_SYS, RESET, PSEL, PENABLE, PWRITE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic PREADY, PSLVERR, RX_FRAME_START, RX_BYTE_VALID;
    logic [7:0] RX_BYTE, RX_L3_OFFSET;
    logic TX_CHECKSUM_ENGINE_ENABLE, RX_CHECKSUM_ENGINE_ENABLE;
    logic RX_CHECKSUM_START_SELECT, RX_OFFSET_VALID;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] exp_rd[$];
    logic [7:0] exp_off[$];
    logic [31:0] w;
    logic exp_err;
    logic [31:0] exp_w;
    logic [7:0] exp_o;
    localparam logic [11:0] OFF = cso_pkg::CTRL_OFFSET;

    cso_control #(
        .MAX_TAGS(2)
    ) cso_control_inst (
        .CLK_SYS(CLK_SYS),
        .RESET(RESET),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR),
        .RX_FRAME_START(RX_FRAME_START),
        .RX_BYTE_VALID(RX_BYTE_VALID),
        .RX_BYTE(RX_BYTE),
        .TX_CHECKSUM_ENGINE_ENABLE(TX_CHECKSUM_ENGINE_ENABLE),
        .RX_CHECKSUM_ENGINE_ENABLE(RX_CHECKSUM_ENGINE_ENABLE),
        .RX_CHECKSUM_START_SELECT(RX_CHECKSUM_START_SELECT),
        .RX_L3_OFFSET(RX_L3_OFFSET),
        .RX_OFFSET_VALID(RX_OFFSET_VALID)
    );

    // 10 MHz system clock
    initial
    begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    task check_word(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task check_off(input logic [7:0] exp, input logic [7:0] got);
        check_word("l3 offset", {24'h0, exp}, {24'h0, got});
    endtask : check_off

    // Enable levels, looked at mid-cycle so the register edge has landed
    task check_ctrl(input cso_pkg::cso_ctrl_t exp);
        @(negedge CLK_SYS);
        check_word("enables", {29'h0, exp}, {29'h0,
            TX_CHECKSUM_ENGINE_ENABLE, RX_CHECKSUM_START_SELECT,
            RX_CHECKSUM_ENGINE_ENABLE});
    endtask : check_ctrl

    // One APB transfer; idle cycle first so no strobe is driven twice
    task apb(input logic wr, input logic [11:0] addr,
        input logic [31:0] data);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= data;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do
        begin
            @(posedge CLK_SYS);
        end
        while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task rd(input logic [11:0] addr, input logic [31:0] exp);
        exp_rd.push_back(exp);
        apb(1'b0, addr, 32'h0);
    endtask : rd

    // Frame: random addresses, given header bytes, random payload
    task frame(input logic [7:0] hdr[$], input logic [7:0] exp);
        logic [7:0] f[$];
        f = {};
        repeat (12) f.push_back(8'($urandom));
        f = {f, hdr};
        repeat (8) f.push_back(8'($urandom));
        exp_off.push_back(exp);
        foreach (f[i])
        begin
            @(posedge CLK_SYS);
            RX_FRAME_START <= (i == 0);
            RX_BYTE_VALID <= 1'b1;
            RX_BYTE <= f[i];
        end
        @(posedge CLK_SYS);
        RX_FRAME_START <= 1'b0;
        RX_BYTE_VALID <= 1'b0;
    endtask : frame

    task wrap_up;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Monitor: results are paired with the oldest note in each queue
    always @(posedge CLK_SYS)
    begin
        if (PSEL && PENABLE && PREADY === 1'b1)
        begin
            exp_err = (PADDR != OFF);
            check_word("pslverr", {31'h0, exp_err}, {31'h0, PSLVERR});
            if (!PWRITE)
            begin
                exp_w = exp_rd.size() ? exp_rd.pop_front() : 32'hx;
                check_word("prdata", exp_w, PRDATA);
            end
        end
        if (RX_OFFSET_VALID === 1'b1)
        begin
            exp_o = exp_off.size() ? exp_off.pop_front() : 8'hx;
            check_off(exp_o, RX_L3_OFFSET);
        end
    end

    // Watchdog sized well above the expected run length
    initial
    begin
        #(4000 * 100);
        errors++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(65));
        RESET = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        RX_FRAME_START = 1'b0;
        RX_BYTE_VALID = 1'b0;
        RX_BYTE = 8'h00;
        repeat (3) @(posedge CLK_SYS);
        RESET <= 1'b0;
        check_ctrl(3'b000);
        rd(OFF, 32'h0000_0000);
        // All ones: only the three control bits may stick
        apb(1'b1, OFF, 32'hffff_ffff);
        check_ctrl(3'b111);
        rd(OFF, 32'h0001_0003);
        repeat (8)
        begin
            w = $urandom;
            apb(1'b1, OFF, w);
            check_ctrl({w[16], w[1], w[0]});
            rd(OFF, w & 32'h0001_0003);
        end
        // Neighbouring and far addresses are refused and change nothing
        apb(1'b1, OFF, 32'h0000_0001);
        apb(1'b1, 12'h12c, 32'hffff_ffff);
        apb(1'b1, 12'h134, 32'hffff_ffff);
        rd(12'h134, 32'h0);
        rd(12'hffc, 32'h0);
        rd(OFF, 32'h0000_0001);
        check_ctrl(3'b001);
        // Fixed start ignores any tag after the addresses
        frame({8'h08, 8'h00}, 8'h0e);
        frame({8'h81, 8'h00, 8'h00, 8'h05, 8'h08, 8'h00}, 8'h0e);
        frame({8'h00, 8'h40, 8'haa, 8'haa, 8'h03, 8'h00, 8'h00, 8'h00,
            8'h08, 8'h00}, 8'h0e);
        // Receive path idle between frames while the fields change
        apb(1'b1, OFF, 32'h0001_0003);
        check_ctrl(3'b111);
        // Layer-3 aware start: plain, tags, snap, llc without snap
        frame({8'h08, 8'h00}, 8'h0e);
        frame({8'h81, 8'h00, 8'h00, 8'h05, 8'h08, 8'h00}, 8'h12);
        frame({8'h81, 8'h00, 8'h00, 8'h05, 8'h81, 8'h00, 8'h00, 8'h07,
            8'h86, 8'hdd}, 8'h16);
        frame({8'h00, 8'h40, 8'haa, 8'haa, 8'h03, 8'h00, 8'h00, 8'h00,
            8'h08, 8'h00}, 8'h16);
        frame({8'h05, 8'hdc, 8'haa, 8'haa, 8'h04, 8'h00}, 8'h0e);
        frame({8'h81, 8'h00, 8'h00, 8'h09, 8'h00, 8'h40, 8'haa, 8'haa,
            8'h03, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00}, 8'h1a);
        // Second reset in mid-run clears every field again
        @(posedge CLK_SYS);
        RESET <= 1'b1;
        @(posedge CLK_SYS);
        RESET <= 1'b0;
        check_ctrl(3'b000);
        rd(OFF, 32'h0000_0000);
        repeat (4) @(posedge CLK_SYS);
        if (exp_rd.size() != 0 || exp_off.size() != 0)
            errors++;
        wrap_up();
    end

endmodule : cso_control_tb

`default_nettype wire
